/* testbench.sv */
// bench for the otg event flag register
module testbench;
  timeunit 1ns/1ns;
  logic core_clk=0,rstn=0,reg_wr=0,reg_rd=0,tmr=0;
  logic [7:0] reg_addr=0;
  logic [31:0] reg_wdata=0,reg_rdata;
  logic [5:0] cmd=1,p;
  logic [6:0] o=1,n;
  int seed=56,fail_count=0,tests_run=0;
  uoef_cable u_cab(.core_clk,.cmd,.p);
  uoef_event_flags #(.STABLE_CYC(8)) u_dut(.*,.flags(),.id_in(p[5]),.ms_timer_expired(tmr),.line_state(p[1:0]),
    .wake_activity(p[2]),.session_end_in(p[4]),.session_valid_in(p[3]));
  initial forever #5 core_clk=~core_clk;
  task chk(logic [31:0] s,x);
    tests_run++;
    fail_count+=s!==x;
    if (s!==x) $display("unexpected %0t %h %h",$time,s,x);
  endtask
  task acc(logic w,logic [7:0] a,logic [31:0] d);
    @(posedge core_clk);
    {reg_wr,reg_rd,reg_addr,reg_wdata}<={w,!w,a,d};
    @(posedge core_clk);
    {reg_wr,reg_rd}<=2'h0;
    #1 if (!w) chk(reg_rdata,d);
  endtask
  // wake stays set while it is high during a clear, since a set beats a clear
  function logic [7:0] ex(logic [6:0] a,b);
    return {a[5]^b[5],b[6],1'b0,a[2]|b[2],!a[4]&&b[4],a[4]^b[4],1'b0,a[3]^b[3]};
  endfunction
  task report_and_stop(int h);
    fail_count+=h;
    $display("checks %0d mismatches %0d",tests_run,fail_count);
    if (fail_count==0&&tests_run>0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial #20us report_and_stop(1);
  initial
  begin
    repeat (10) @(posedge core_clk);
    rstn<=1;
    repeat (14) @(posedge core_clk);
    acc(0,8'h00,32'h20);
    acc(0,8'h04,32'h0);
    repeat (30)
    begin
      n=7'($random(seed))&7'h7C|7'h01;
      acc(1,8'h00,32'hFF);
      @(posedge core_clk) {tmr,cmd}<=n;
      repeat (3) @(posedge core_clk) tmr<=0;
      acc(0,8'h00,{24'h0,ex(o,n)});
      o=n;
    end
    report_and_stop(0);
  end
endmodule // testbench

/* uoef_cable.sv */
// cable side pins, moved by a command word
module uoef_cable(input logic core_clk,input logic [5:0] cmd,output logic [5:0] p);
  timeunit 1ns/1ns;
  always @(posedge core_clk)
    p<=cmd;
endmodule // uoef_cable

/* uoef_checker.sv */
// checker on the otg event flag ports
module uoef_checker(input logic core_clk,rstn,reg_wr,reg_rd,id_in,ms_timer_expired,wake_activity,session_end_in,
  session_valid_in,input logic [7:0] reg_addr,flags,input logic [31:0] reg_rdata);
  timeunit 1ns/1ns;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  a_id_set: assert property ($changed(id_in)|=>flags[7]) else $error("id");
  a_tmr_set: assert property (ms_timer_expired|=>flags[6]) else $error("tmr");
  a_wake_set: assert property (wake_activity|=>flags[4]) else $error("wake");
  a_vbus_drop: assert property ($rose(session_end_in)|=>flags[3]) else $error("drop");
  a_end_chg: assert property ($changed(session_end_in)|=>flags[2]) else $error("end");
  a_vld_chg: assert property ($changed(session_valid_in)|=>flags[0]) else $error("vld");
  a_flag_hold: assert property (flags[7]&&!reg_wr|=>flags[7]) else $error("hold");
  a_read_data: assert property (reg_rd&&reg_addr==0|=>reg_rdata=={24'h0,$past(flags)}) else $error("rd");
  a_unused_zero: assert property (reg_rdata[31:8]==24'h0&&reg_rdata[1]==1'b0&&flags[1]==1'b0) else $error("unused");
  a_rdata_idle: assert property (!reg_rd|=>reg_rdata==32'h0) else $error("idle");
endmodule // uoef_checker
bind uoef_event_flags uoef_checker u_chk(.*);

/* uoef_event_flags.v */
// otg event flag register with hardware set and write-one-to-clear
`include "uoef_regs.vh"

// Functional notes
// - a change of the id input sets the id change flag in bit 7.
// - expiry of the one millisecond timer sets the timer flag in bit 6.
// - bit 5 is set when the line state has held for 1 ms and differs from the last recorded stable state.
// - a wake caused by activity on d+, d-, id or vbus sets the activity flag in bit 4.
// - vbus falling below the session end level sets the flag in bit 3.
// - a change on the session end comparator input sets the flag in bit 2.
// - a change on the session valid comparator input sets the flag in bit 0.
// - flags are set only by hardware, are readable, and a written one clears them.
// - bits 31 to 8 and bit 1 hold nothing and read as zero.
module uoef_event_flags #(
  parameter STABLE_CYC = `UOEF_STABLE_CYC
) (
  input wire core_clk,
  input wire rstn,
  input wire [`UOEF_ADDR_W-1:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire id_in,
  input wire ms_timer_expired,
  input wire [1:0] line_state,
  input wire wake_activity,
  input wire session_end_in,
  input wire session_valid_in,
  output wire [7:0] flags
);

  reg [7:0] flags_q;
  reg [7:0] flags_d;
  reg id_q;
  reg sesend_q;
  reg sesvld_q;
  reg inputs_seen_q;
  reg [1:0] line_q;
  reg [1:0] line_rec_q;
  reg [31:0] stable_cnt_q;
  reg stable_done_q;
  reg [7:0] set_vec;
  reg [7:0] clr_vec;
  wire line_fire;

  // line counter restarts on any change; fires at most once per stable interval, and only if the state differs from the recorded one
  assign line_fire = (line_state == line_q) && !stable_done_q && (stable_cnt_q == STABLE_CYC - 1) &&
                     (line_state != line_rec_q);

  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      line_q <= 2'h0;
      line_rec_q <= 2'h0;
      stable_cnt_q <= 32'h0;
      stable_done_q <= 1'b0;
    end
    else
    begin
      line_q <= line_state;
      if (line_state != line_q)
      begin
        stable_cnt_q <= 32'h0;
        stable_done_q <= 1'b0;
      end
      else if (!stable_done_q)
      begin
        if (stable_cnt_q == STABLE_CYC - 1)
        begin
          stable_done_q <= 1'b1;
          line_rec_q <= line_state;
        end
        else
          stable_cnt_q <= stable_cnt_q + 32'h1;
      end
    end
  end

  // previous comparator levels; first cycle after reset only captures them
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      id_q <= 1'b0;
      sesend_q <= 1'b0;
      sesvld_q <= 1'b0;
      inputs_seen_q <= 1'b0;
    end
    else
    begin
      id_q <= id_in;
      sesend_q <= session_end_in;
      sesvld_q <= session_valid_in;
      inputs_seen_q <= 1'b1;
    end
  end

  always @*
  begin
    set_vec = 8'h00;
    set_vec[`UOEF_BIT_ID] = inputs_seen_q && (id_in != id_q);
    set_vec[`UOEF_BIT_TMR] = ms_timer_expired;
    set_vec[`UOEF_BIT_LST] = line_fire;
    set_vec[`UOEF_BIT_ACT] = wake_activity;
    // session end rising means vbus dropped below the session end level
    set_vec[`UOEF_BIT_SESV] = inputs_seen_q && session_end_in && !sesend_q;
    set_vec[`UOEF_BIT_BVB] = inputs_seen_q && (session_end_in != sesend_q);
    set_vec[`UOEF_BIT_AVB] = inputs_seen_q && (session_valid_in != sesvld_q);
    clr_vec = 8'h00;
    if (reg_wr && reg_addr == `UOEF_OFS_FLAGS)
      clr_vec = reg_wdata[7:0];
    // set wins over clear so no event is lost
    flags_d = ((flags_q & ~clr_vec) | set_vec) & `UOEF_FLAGS_MASK;
  end

  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      flags_q <= `UOEF_FLAGS_RST;
    else
      flags_q <= flags_d;
  end

  // read data valid the cycle after the strobe only; unmapped reads give zero
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd && reg_addr == `UOEF_OFS_FLAGS)
      reg_rdata <= {24'h000000, flags_q & `UOEF_FLAGS_MASK};
    else
      reg_rdata <= 32'h0000_0000;
  end

  assign flags = flags_q;

endmodule // uoef_event_flags

/* uoef_regs.vh */
// register offsets, field positions, reset values and timing counts for the otg event flag block
`ifndef UOEF_REGS_VH
`define UOEF_REGS_VH
`define UOEF_ADDR_W 8
`define UOEF_OFS_FLAGS 8'h00
`define UOEF_BIT_ID 7
`define UOEF_BIT_TMR 6
`define UOEF_BIT_LST 5
`define UOEF_BIT_ACT 4
`define UOEF_BIT_SESV 3
`define UOEF_BIT_BVB 2
`define UOEF_BIT_AVB 0
`define UOEF_FLAGS_RST 8'h00
`define UOEF_FLAGS_MASK 8'hFD
`define UOEF_CLK_MHZ 100
`define UOEF_STABLE_US 1000
`define UOEF_STABLE_CYC (`UOEF_STABLE_US * `UOEF_CLK_MHZ)
`endif
